// ---- shared/wsc_pkg.sv ----
// constants and types shared by the workspace stack cache block
// assumes one processor clock and word-addressed workspace pointers
//
// What this block does
// - keep local copy of lowest 32 workspace words from the pointer
// - two independent read ports and one write port each cycle
// - every local write is also forwarded to the main cache
// - 32-entry circular buffer indexed by low five pointer bits
// - pointer moving down invalidates entries rolling in; access revalidates
// - read of invalid entry fetches from main cache and stores locally
// - pointer moving up invalidates entries rolling out
// - context switch or interrupt clears every valid flag
// - pointer move of 32 words or more invalidates all entries
// - local reads of valid entries answer within the first pipeline stage cycle unless the other port misses
// - two local reads plus two main cache reads per cycle possible
// - after reset main storage is 16 Kbytes of direct single-cycle RAM
// - storage configurable all cache, all RAM, or 8K/8K split
`default_nettype none
package wsc_pkg;
  localparam int WSC_ENTRIES = 32;
  localparam int WSC_IDX_W = 5;
  localparam int WSC_DATA_W = 32;
  localparam int WSC_ADDR_W = 30;
  localparam int WSC_MAIN_BYTES = 16384;
  localparam int WSC_HALF_BYTES = 8192;
  localparam int WSC_MAIN_WORDS = WSC_MAIN_BYTES / 4;
  localparam int WSC_MAIN_AW = 12;
  localparam int WSC_HALF_WORDS = WSC_HALF_BYTES / 4;
  localparam logic [WSC_ENTRIES-1:0] WSC_VALID_RST = 32'h0;
  localparam logic [WSC_DATA_W-1:0] WSC_DATA_RST = 32'h0;
  // storage split modes
  typedef enum logic [1:0] {
    WSC_SPLIT_RAM = 2'b00,
    WSC_SPLIT_HALF = 2'b01,
    WSC_SPLIT_CACHE = 2'b10
  } wsc_split_e;
  localparam wsc_split_e WSC_SPLIT_RST = WSC_SPLIT_RAM;
  // fill sequencer states
  typedef enum logic [1:0] {
    WSC_IDLE = 2'b00,
    WSC_FILL_A = 2'b01,
    WSC_FILL_B = 2'b10
  } wsc_state_e;
endpackage
`default_nettype wire

// ---- hdl/wsc_main_store.sv ----
// on-chip main storage run as directly addressed RAM with two read ports
// assumes the cache tag side sits elsewhere; only RAM-mapped words live here
`default_nettype none
module wsc_main_store (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // configuration
  input wire wsc_pkg::wsc_split_e i_split,
  // write port
  input wire logic i_wr,
  input wire logic [wsc_pkg::WSC_ADDR_W-1:0] i_waddr,
  input wire logic [wsc_pkg::WSC_DATA_W-1:0] i_wdata,
  // two read ports
  input wire logic [1:0] i_rd,
  input wire logic [2*wsc_pkg::WSC_ADDR_W-1:0] i_raddr,
  output logic [1:0] o_rvalid,
  output logic [2*wsc_pkg::WSC_DATA_W-1:0] o_rdata,
  output logic [1:0] o_rmiss
);
  import wsc_pkg::*;

  logic [WSC_DATA_W-1:0] mem [WSC_MAIN_WORDS];
  logic [1:0] rvalid;
  logic [1:0] next_rvalid;
  logic [1:0] rmiss;
  logic [1:0] next_rmiss;
  logic [2*WSC_DATA_W-1:0] rdata;

  // word lies in the RAM-mapped part for the current split
  function automatic logic in_ram(input wsc_split_e s, input logic [WSC_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (s == WSC_SPLIT_RAM) begin
      hit = (a < WSC_ADDR_W'(WSC_MAIN_WORDS));
    end else if (s == WSC_SPLIT_HALF) begin
      hit = (a < WSC_ADDR_W'(WSC_HALF_WORDS));
    end
    return hit;
  endfunction

  // read answer flags; out-of-RAM reads report a miss for the cache side
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      next_rvalid[p] = i_rd[p] && in_ram(i_split, i_raddr[p*WSC_ADDR_W +: WSC_ADDR_W]);
      next_rmiss[p] = i_rd[p] && !next_rvalid[p];
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rvalid <= 2'h0;
      rmiss <= 2'h0;
    end else begin
      rvalid <= next_rvalid;
      rmiss <= next_rmiss;
    end
  end

  // single-cycle storage array, no reset on data
  always_ff @(posedge i_mclk) begin
    if (i_wr && in_ram(i_split, i_waddr)) begin
      mem[i_waddr[WSC_MAIN_AW-1:0]] <= i_wdata;
    end
    for (int p = 0; p < 2; p++) begin
      rdata[p*WSC_DATA_W +: WSC_DATA_W] <=
        mem[i_raddr[p*WSC_ADDR_W +: WSC_MAIN_AW]];
    end
  end

  assign o_rvalid = rvalid;
  assign o_rmiss = rmiss;
  assign o_rdata = rdata;
endmodule
`default_nettype wire

// ---- hdl/wsc_top.sv ----
// workspace stack cache: 32-word circular copy of the local workspace
// assumes pipeline reads offsets from the workspace pointer, one clock only
`default_nettype none
module wsc_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // storage configuration, set during initialisation
  input wire logic i_split_load,
  input wire wsc_pkg::wsc_split_e i_split,
  // workspace pointer and context control
  input wire logic i_wptr_load,
  input wire logic [wsc_pkg::WSC_ADDR_W-1:0] i_wptr,
  input wire logic i_ctx_flush,
  // two local read ports (offset from pointer)
  input wire logic [1:0] i_lrd,
  input wire logic [2*wsc_pkg::WSC_IDX_W-1:0] i_lrd_off,
  output logic [1:0] o_lrd_ok,
  output logic [2*wsc_pkg::WSC_DATA_W-1:0] o_lrd_data,
  output logic o_stall,
  // local write port
  input wire logic i_lwr,
  input wire logic [wsc_pkg::WSC_IDX_W-1:0] i_lwr_off,
  input wire logic [wsc_pkg::WSC_DATA_W-1:0] i_lwr_data,
  // two non-local main reads
  input wire logic [1:0] i_nrd,
  input wire logic [2*wsc_pkg::WSC_ADDR_W-1:0] i_nrd_addr,
  output logic [1:0] o_nrd_ok,
  output logic [2*wsc_pkg::WSC_DATA_W-1:0] o_nrd_data,
  output logic [1:0] o_nrd_miss,
  // non-local write
  input wire logic i_nwr,
  input wire logic [wsc_pkg::WSC_ADDR_W-1:0] i_nwr_addr,
  input wire logic [wsc_pkg::WSC_DATA_W-1:0] i_nwr_data,
  // state view
  output logic [wsc_pkg::WSC_ENTRIES-1:0] o_valid,
  output wsc_pkg::wsc_split_e o_split
);
  import wsc_pkg::*;

  logic [WSC_DATA_W-1:0] ent [WSC_ENTRIES];
  logic [WSC_ENTRIES-1:0] valid;
  logic [WSC_ENTRIES-1:0] next_valid;
  logic [WSC_ADDR_W-1:0] wptr;
  logic [WSC_ADDR_W-1:0] next_wptr;
  wsc_split_e split;
  wsc_split_e next_split;
  wsc_state_e state;
  wsc_state_e next_state;
  logic [1:0] need;
  logic [1:0] next_need;
  logic [2*WSC_DATA_W-1:0] lrd_data;
  logic [2*WSC_DATA_W-1:0] next_lrd_data;
  logic [1:0] lrd_ok;
  logic [1:0] next_lrd_ok;
  logic [WSC_IDX_W-1:0] idx [2];
  logic [WSC_IDX_W-1:0] widx;
  logic [1:0] hit;
  logic [1:0] m_rd;
  logic [2*WSC_ADDR_W-1:0] m_raddr;
  logic [1:0] m_ok;
  logic [2*WSC_DATA_W-1:0] m_data;
  logic [1:0] m_miss;
  logic m_wr;
  logic [WSC_ADDR_W-1:0] m_waddr;
  logic [WSC_DATA_W-1:0] m_wdata;
  logic [1:0] fill_we;

  // entry of a workspace offset: low five bits of pointer plus offset
  function automatic logic [WSC_IDX_W-1:0] slot(input logic [WSC_ADDR_W-1:0] p,
                                               input logic [WSC_IDX_W-1:0] off);
    return WSC_IDX_W'(p[WSC_IDX_W-1:0] + off);
  endfunction

  // mask of entries crossed by a pointer move
  function automatic logic [WSC_ENTRIES-1:0] roll(input logic [WSC_ADDR_W-1:0] o,
                                                 input logic [WSC_ADDR_W-1:0] n);
    logic [WSC_ENTRIES-1:0] m;
    logic [WSC_ADDR_W-1:0] d;
    logic [WSC_IDX_W-1:0] lo;
    m = '0;
    d = (n > o) ? WSC_ADDR_W'(n - o) : WSC_ADDR_W'(o - n);
    lo = (n > o) ? o[WSC_IDX_W-1:0] : n[WSC_IDX_W-1:0];
    if (d >= WSC_ADDR_W'(WSC_ENTRIES)) begin
      m = '1;
    end else begin
      for (int k = 0; k < WSC_ENTRIES; k++) begin
        if (WSC_ADDR_W'(k) < d) begin
          m[WSC_IDX_W'(lo + WSC_IDX_W'(k))] = 1'b1;
        end
      end
    end
    return m;
  endfunction

  // decode read slots and hits, both ports in parallel
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      idx[p] = slot(wptr, i_lrd_off[p*WSC_IDX_W +: WSC_IDX_W]);
      hit[p] = valid[idx[p]];
    end
    widx = slot(wptr, i_lwr_off);
  end

  // main storage ports: fills take priority over non-local reads
  always_comb begin
    m_rd = i_nrd;
    m_raddr = i_nrd_addr;
    if (state == WSC_FILL_A) begin
      for (int p = 0; p < 2; p++) begin
        if (need[p]) begin
          m_rd[p] = 1'b1;
          m_raddr[p*WSC_ADDR_W +: WSC_ADDR_W] =
            wptr + WSC_ADDR_W'(i_lrd_off[p*WSC_IDX_W +: WSC_IDX_W]);
        end
      end
    end
    m_wr = i_lwr || i_nwr;
    m_waddr = i_lwr ? WSC_ADDR_W'(wptr + WSC_ADDR_W'(i_lwr_off)) : i_nwr_addr;
    m_wdata = i_lwr ? i_lwr_data : i_nwr_data;
  end

  // fill sequencer, valid flags, pointer and split
  always_comb begin
    next_state = state;
    next_need = need;
    next_valid = valid;
    next_wptr = wptr;
    next_split = split;
    next_lrd_ok = 2'h0;
    next_lrd_data = lrd_data;
    fill_we = 2'h0;
    if (i_split_load) begin
      next_split = i_split;
    end
    case (state)
      WSC_IDLE: begin
        for (int p = 0; p < 2; p++) begin
          if (i_lrd[p] && hit[p]) begin
            next_lrd_ok[p] = 1'b1;
            next_lrd_data[p*WSC_DATA_W +: WSC_DATA_W] = ent[idx[p]];
          end
        end
        if (|(i_lrd & ~hit)) begin
          next_need = i_lrd & ~hit;
          next_lrd_ok = 2'h0;
          next_state = WSC_FILL_A;
        end
      end
      WSC_FILL_A: begin
        next_state = WSC_FILL_B;
      end
      WSC_FILL_B: begin
        for (int p = 0; p < 2; p++) begin
          if (need[p]) begin
            fill_we[p] = 1'b1;
            next_valid[idx[p]] = 1'b1;
            next_lrd_data[p*WSC_DATA_W +: WSC_DATA_W] = m_data[p*WSC_DATA_W +: WSC_DATA_W];
          end else begin
            next_lrd_data[p*WSC_DATA_W +: WSC_DATA_W] = ent[idx[p]];
          end
        end
        next_lrd_ok = i_lrd;
        next_need = 2'h0;
        next_state = WSC_IDLE;
      end
      default: begin
        next_state = WSC_IDLE;
      end
    endcase
    if (i_lwr) begin
      next_valid[widx] = 1'b1;
    end
    if (i_wptr_load) begin
      next_valid = next_valid & ~roll(wptr, i_wptr);
      next_wptr = i_wptr;
    end
    if (i_ctx_flush) begin
      next_valid = '0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= WSC_IDLE;
      need <= 2'h0;
      valid <= WSC_VALID_RST;
      wptr <= '0;
      split <= WSC_SPLIT_RST;
      lrd_ok <= 2'h0;
      lrd_data <= '0;
    end else begin
      state <= next_state;
      need <= next_need;
      valid <= next_valid;
      wptr <= next_wptr;
      split <= next_split;
      lrd_ok <= next_lrd_ok;
      lrd_data <= next_lrd_data;
    end
  end

  // local entry storage: one write port plus fill writes
  always_ff @(posedge i_mclk) begin
    for (int p = 0; p < 2; p++) begin
      if (fill_we[p] && !(i_lwr && widx == idx[p])) begin
        ent[idx[p]] <= m_data[p*WSC_DATA_W +: WSC_DATA_W];
      end
    end
    if (i_lwr) begin
      ent[widx] <= i_lwr_data;
    end
  end

  wsc_main_store wsc_main_store_inst (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_split(split),
    .i_wr(m_wr),
    .i_waddr(m_waddr),
    .i_wdata(m_wdata),
    .i_rd(m_rd),
    .i_raddr(m_raddr),
    .o_rvalid(m_ok),
    .o_rdata(m_data),
    .o_rmiss(m_miss)
  );

  // outputs; non-local answers are masked while a fill owns the ports
  assign o_stall = (state != WSC_IDLE);
  assign o_lrd_ok = lrd_ok;
  assign o_lrd_data = lrd_data;
  assign o_nrd_ok = (state == WSC_FILL_B) ? 2'h0 : m_ok;
  assign o_nrd_miss = (state == WSC_FILL_B) ? 2'h0 : m_miss;
  assign o_nrd_data = m_data;
  assign o_valid = valid;
  assign o_split = split;
endmodule
`default_nettype wire

// ---- verif/wsc_pipe_model.sv ----
// pipeline side model: raises local reads and holds them until answered
// assumes answers are sampled on the falling edge of i_mclk
`default_nettype none
module wsc_pipe_model (
  // clock and start from the bench
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [1:0] i_req,
  input wire logic [9:0] i_off,
  // answers and requests
  input wire logic [1:0] i_ok,
  output logic [1:0] o_lrd,
  output logic [9:0] o_off,
  output int o_lat
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle at time zero
  initial begin
    o_lrd = '0;
    o_off = '0;
    o_lat = 0;
  end
  // hold each port until answered, then the offsets go stale
  always @(negedge i_mclk) begin
    if (i_go) begin
      o_lrd <= i_req;
      o_off <= i_off;
      o_lat <= 0;
    end else if (o_lrd != 0) begin
      o_lat <= o_lat + 1;
      o_lrd <= o_lrd & ~i_ok;
      if ((o_lrd & ~i_ok) == 0) o_off <= ~o_off;
    end
  end
endmodule
`default_nettype wire

// ---- verif/wsc_chk.sv ----
// assertions on the workspace stack cache top ports
// assumes one clock; bound onto every wsc_top
`default_nettype none
module wsc_chk (
  // all watched top ports
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_wptr_load,
  input wire logic [wsc_pkg::WSC_ADDR_W-1:0] i_wptr,
  input wire logic i_ctx_flush,
  input wire logic [1:0] i_lrd,
  input wire logic [2*wsc_pkg::WSC_IDX_W-1:0] i_lrd_off,
  input wire logic [1:0] o_lrd_ok,
  input wire logic o_stall,
  input wire logic i_lwr,
  input wire logic [wsc_pkg::WSC_IDX_W-1:0] i_lwr_off,
  input wire logic [1:0] i_nrd,
  input wire logic [2*wsc_pkg::WSC_ADDR_W-1:0] i_nrd_addr,
  input wire logic [1:0] o_nrd_ok,
  input wire logic [1:0] o_nrd_miss,
  input wire logic [wsc_pkg::WSC_ENTRIES-1:0] o_valid,
  input wire wsc_pkg::wsc_split_e o_split
);
  import wsc_pkg::*;
  logic [29:0] wp;
  logic [29:0] dl;
  logic [4:0] ix0;
  logic [4:0] ixw;
  logic [4:0] ix1;
  // move distance and entry indices
  assign dl = (i_wptr > wp) ? i_wptr - wp : wp - i_wptr;
  assign ix0 = wp[4:0] + i_lrd_off[4:0];
  assign ix1 = wp[4:0] + i_lrd_off[9:5];
  assign ixw = wp[4:0] + i_lwr_off;
  // pointer as the design holds it
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) wp <= '0;
    else if (i_wptr_load) wp <= i_wptr;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // a miss on the other port holds both answers back for the fill
  a_hit_one_cycle: assert property (i_lrd[0] && !o_stall && o_valid[ix0]
    && !(i_lrd[1] && !o_valid[ix1]) && !i_wptr_load && !i_ctx_flush |=> o_lrd_ok[0])
    else $error("hit not answered next cycle");
  a_fill_stall_len: assert property ($rose(o_stall) |-> o_stall[*2] ##1 !o_stall)
    else $error("fill stall length wrong");
  a_fill_answer: assert property ($fell(o_stall) |-> o_lrd_ok != '0)
    else $error("fill ended without answer");
  a_flush_clears: assert property (i_ctx_flush |=> o_valid == '0)
    else $error("flush left valid entries");
  a_write_valid: assert property (i_lwr && !i_wptr_load && !i_ctx_flush
    |=> o_valid[$past(ixw)]) else $error("write did not set valid");
  a_big_move: assert property (i_wptr_load && dl >= 32 && !o_stall |=> o_valid == '0)
    else $error("large move left valid entries");
  a_main_answers: assert property (i_nrd[0] && !o_stall
    |=> o_nrd_ok[0] != o_nrd_miss[0]) else $error("main read not answered");
  a_cache_misses: assert property (o_split == WSC_SPLIT_CACHE && i_nrd[0] && !o_stall
    |=> o_nrd_miss[0] && !o_nrd_ok[0]) else $error("cache mode read not missed");
  a_ram_reads: assert property (o_split == WSC_SPLIT_RAM && i_nrd[0] && !o_stall
    && i_nrd_addr[29:12] == '0 |=> o_nrd_ok[0]) else $error("ram read not answered");
  // main scenarios reached
  c_fill: cover property ($rose(o_stall));
  c_flush: cover property (i_ctx_flush);
  c_big_move: cover property (i_wptr_load && dl >= 32);
endmodule
bind wsc_top wsc_chk wsc_chk_inst (.*);
`default_nettype wire

// ---- verif/wsc_top_bench.sv ----
// self-checking bench for the workspace stack cache
// assumes the pipeline model holds local reads until answered
`default_nettype none
module wsc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import wsc_pkg::*;
  `define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
  logic i_mclk = 0, i_arst_n = 0, i_split_load = 0, i_wptr_load = 0, i_ctx_flush = 0;
  logic i_lwr = 0, i_nwr = 0, go = 0, o_stall;
  wsc_split_e i_split = WSC_SPLIT_RAM, o_split;
  logic [29:0] i_wptr = '0, i_nwr_addr = '0;
  logic [59:0] i_nrd_addr = '0;
  logic [1:0] i_nrd = '0, rq = '0, i_lrd, o_lrd_ok, o_nrd_ok, o_nrd_miss;
  logic [9:0] i_lrd_off, off = '0;
  logic [4:0] i_lwr_off = '0;
  logic [31:0] i_lwr_data = '0, i_nwr_data = '0, o_valid, vm = '0;
  logic [63:0] o_lrd_data, o_nrd_data;
  logic [31:0] mem [int];
  int wp = 0, n_mismatch = 0, samples_checked = 0, lat, b;
  wsc_top wsc_top_inst (.*);
  wsc_pipe_model wsc_pipe_model_inst (.i_mclk(i_mclk), .i_go(go), .i_req(rq), .i_off(off),
    .i_ok(o_lrd_ok), .o_lrd(i_lrd), .o_off(i_lrd_off), .o_lat(lat));
  initial forever #5 i_mclk = ~i_mclk;
  task nx;
    @(negedge i_mclk);
    #1;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // local write, mirrored into the main memory model
  task lw(int o, logic [31:0] d);
    i_lwr = 1;
    i_lwr_off = 5'(o);
    i_lwr_data = d;
    nx;
    i_lwr = 0;
    nx;
    vm[5'(wp + o)] = 1'b1;
    mem[wp + o] = d;
  endtask
  task nw(int a, logic [31:0] d);
    i_nwr = 1;
    i_nwr_addr = 30'(a);
    i_nwr_data = d;
    nx;
    i_nwr = 0;
    nx;
    mem[a] = d;
  endtask
  // both main read ports at one address
  task nr(int a, logic k);
    i_nrd = 2'b11;
    i_nrd_addr = {2{30'(a)}};
    nx;
    i_nrd = 0;
    i_nrd_addr = ~i_nrd_addr;
    `CHK("nrd_ok", {k, k}, o_nrd_ok)
    `CHK("nrd_miss", {!k, !k}, o_nrd_miss)
    if (k) `CHK("nrd_data", {2{mem[a]}}, o_nrd_data)
    nx;
  endtask
  task mv(int n);
    int d;
    d = n - wp;
    i_wptr_load = 1;
    i_wptr = 30'(n);
    nx;
    i_wptr_load = 0;
    nx;
    if (d >= 32 || d <= -32) vm = '0;
    else for (int i = 0; i < (d < 0 ? -d : d); i++) vm[5'((d < 0 ? n : wp) + i)] = 0;
    wp = n;
    `CHK("valid", vm, o_valid)
  endtask
  // local read through the pipeline model
  task rd(logic [1:0] r, int o0, int o1, int lt);
    int k;
    int ix;
    rq = r;
    off = {5'(o1), 5'(o0)};
    go = 1;
    nx;
    go = 0;
    k = 0;
    do begin
      nx;
      k++;
    end while (i_lrd != 0 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      report_and_stop;
    end
    `CHK("latency", lt, lat)
    for (int p = 0; p < 2; p++) if (r[p]) begin
      ix = wp + (p ? o1 : o0);
      `CHK("lrd_data", mem[ix], o_lrd_data[p*32 +: 32])
      vm[5'(ix)] = 1'b1;
    end
    `CHK("valid", vm, o_valid)
  endtask
  task sp(wsc_split_e m, logic k);
    i_split_load = 1;
    i_split = m;
    nx;
    i_split_load = 0;
    nx;
    `CHK("split", m, o_split)
    nr(3000, m == WSC_SPLIT_RAM);
    nr(1000, k);
  endtask
  initial begin
    void'($urandom(32'h8140D184));
    repeat (10) @(negedge i_mclk);
    i_arst_n = 1;
    nx;
    `CHK("valid", 32'h0, o_valid)
    `CHK("split", WSC_SPLIT_RST, o_split)
    b = 200 + $urandom % 40;
    mv(b);
    for (int i = 0; i < 4; i++) lw(i, $urandom);
    for (int i = 0; i < 4; i++) nr(b + i, 1);
    $display("write-through test done");
    nw(b + 5, $urandom);
    rd(2'b01, 5, 0, 3);
    rd(2'b11, 0, 5, 1);
    $display("read test done");
    nw(b - 4, $urandom);
    mv(b - 4);
    rd(2'b11, 0, 4, 3);
    mv(b);
    mv(b + 40);
    lw(1, $urandom);
    i_ctx_flush = 1;
    nx;
    i_ctx_flush = 0;
    nx;
    // model forgets every entry as well
    vm = '0;
    `CHK("valid", 32'h0, o_valid)
    // flushed word comes back from the write-through copy
    rd(2'b01, 1, 0, 3);
    $display("move test done");
    nw(1000, $urandom);
    nw(3000, $urandom);
    sp(WSC_SPLIT_RAM, 1);
    sp(WSC_SPLIT_HALF, 1);
    sp(WSC_SPLIT_CACHE, 0);
    $display("split test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
